//--- dv/smb_master.sv
// bus master model: frames, bytes and ack slots on the link
// assumes the port pulls data low through oe; the line has a pull-up
`timescale 1ns/10ps
module smb_master (
	// link toward the port
	output logic serial_clock,
	output logic serial_data_in,
	input wire logic serial_data_oe
);
	logic drv = 1'b1;
	// wired and: low if either party pulls, else pulled up
	assign serial_data_in = drv & ~serial_data_oe;
	// clock stands high outside frames
	initial serial_clock = 1'b1;
	// data falls while clock high
	task automatic start();
		drv = 1'b1;
		#40 serial_clock = 1'b1;
		#40 drv = 1'b0;
		#40 serial_clock = 1'b0;
	endtask
	// data rises while clock high, then both rest high
	task automatic stop();
		drv = 1'b0;
		#40 serial_clock = 1'b1;
		#40 drv = 1'b1;
		#80;
	endtask
	// eight bits msb first then the ack slot; 1 releases the line
	task automatic xb(input logic [8:0] b, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) begin
			#40 drv = b[i];
			#40 serial_clock = 1'b1;
			#40 r[i] = serial_data_in;
			#40 serial_clock = 1'b0;
		end
	endtask
endmodule

//--- dv/smb_props.sv
// checker for the slave port: link and pulse relations at the ports
// assumes a bind from the bench top; clk_sys domain only
`timescale 1ns/10ps
module smb_props (
	// system side
	input wire logic clk_sys,
	input wire logic resetn,
	// link
	input wire logic serial_clock,
	input wire logic serial_data_out,
	input wire logic serial_data_oe,
	// register side
	input wire logic [2:0] reg_ptr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic alert_release
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// oe may only move in the low half of the link clock
	AST_OE_EDGE: assert property (
		$changed(serial_data_oe) |-> !serial_clock)
		else $error("oe moved while link clock high");
	AST_OE_HOLD: assert property (
		serial_clock [*2] |-> $stable(serial_data_oe))
		else $error("oe not held in high phase");
	AST_OUT_LOW: assert property (serial_data_oe |-> !serial_data_out)
		else $error("open drain drives high");
	// write data only moves with its pulse
	AST_WDATA: assert property ($changed(reg_wdata) |-> reg_write)
		else $error("write data moved without pulse");
	// one write per transaction, so pulses are far apart
	AST_WR_GAP: assert property (reg_write |=> !reg_write [*8])
		else $error("write pulses too close");
	AST_REL: assert property (
		$rose(alert_release) |=> $fell(alert_release))
		else $error("release not one cycle");
	AST_PTR: assert property (
		$changed(reg_ptr) |-> !reg_write && !$past(reg_write))
		else $error("pointer moved at a write");
	AST_REL_WR: assert property (alert_release |-> !reg_write)
		else $error("release together with write");
	C_WR: cover property (reg_write);
	C_REL: cover property (alert_release);
	C_PTR: cover property ($changed(reg_ptr));
endmodule

//--- dv/smb_slave_port_tb.sv
// self-checking bench for the slave port, master model on the link
// assumes the hand-over timing; the register set is modelled here
`timescale 1ns/10ps
module smb_slave_port_tb;
	logic clk_sys = 1'b0;
	logic resetn = 1'b1;
	logic serial_clock, serial_data_in, serial_data_out, serial_data_oe;
	logic [6:0] own_address;
	logic broadcast_write_enable = 1'b0;
	logic alert_active = 1'b0;
	logic [7:0] reg_rdata = 8'h00;
	logic [2:0] reg_ptr, p;
	logic [7:0] reg_wdata, d;
	logic reg_write, alert_release;
	logic [7:0] regs [8];
	logic [7:0] shadow [8];
	logic [10:0] exp_q [$];
	logic [8:0] r;
	int n_fail = 0;
	int checks_done = 0;
	int cyc = 0;
	int n_rel = 0;
	smb_slave_port dut (.clk_sys(clk_sys), .resetn(resetn),
		.serial_clock(serial_clock), .serial_data_in(serial_data_in),
		.serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
		.own_address(own_address), .alert_active(alert_active),
		.broadcast_write_enable(broadcast_write_enable),
		.reg_rdata(reg_rdata), .reg_ptr(reg_ptr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .alert_release(alert_release));
	smb_master bus (.serial_clock(serial_clock),
		.serial_data_in(serial_data_in), .serial_data_oe(serial_data_oe));
	initial forever #12.5 clk_sys = ~clk_sys;
	task automatic check(input string w, input logic [10:0] s,
		input logic [10:0] e);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("FAIL %s exp %h seen %h", w, e, s);
		end
	endtask
	task automatic results();
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// register set and monitor; pulses sampled once settled
	always @(negedge clk_sys) begin
		if (reg_write === 1'b1) begin
			regs[reg_ptr] = reg_wdata;
			if (exp_q.size() == 0)
				check("extra write", 11'h0, 11'h7ff);
			else
				check("write", {reg_ptr, reg_wdata}, exp_q.pop_front());
		end
		if (alert_release === 1'b1)
			n_rel++;
		reg_rdata <= regs[reg_ptr];
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end
	task automatic addr(input logic [6:0] a, input logic rd, input logic ok);
		bus.xb({a, rd, 1'b1}, r);
		check("addr ack", r[0], !ok);
	endtask
	// command then nb data bytes; only the first may land
	task automatic wr(input logic [6:0] a, input logic ok, input int nb);
		if (ok) begin
			p = 3'($urandom);
			d = 8'($urandom);
			shadow[p] = d;
			exp_q.push_back({p, d});
		end
		bus.start();
		addr(a, 1'b0, ok);
		bus.xb({5'($urandom), p, 1'b1}, r);
		check("cmd ack", r[0], !ok);
		// first byte is the one noted; later bytes differ so a stray write shows
		repeat (nb) begin
			bus.xb({d, 1'b1}, r);
			d = ~d;
			check("data ack", r[0], !ok);
		end
		bus.stop();
		#1000;
		check("idle", serial_data_in, 1'b1);
	endtask
	// optional pointer set and repeated start, then nb bytes read
	task automatic rd(input logic [6:0] a, input logic ok, input logic setp,
		input int nb, input logic [7:0] e);
		bus.start();
		if (setp) begin
			addr(a, 1'b0, 1'b1);
			bus.xb({5'h0, p, 1'b1}, r);
			bus.start();
		end
		addr(a, 1'b1, ok);
		for (int i = 1; i <= nb; i++) begin
			bus.xb({8'hff, i == nb}, r);
			check("read", r[8:1], e);
		end
		bus.stop();
		#1000;
	endtask
	initial begin
		void'($urandom(30));
		// a real falling edge, so the asynchronously reset link flops clear
		#1 resetn = 1'b0;
		own_address = {3'h4, 4'($urandom)};
		for (int i = 0; i < 8; i++) begin
			regs[i] = 8'($urandom);
			shadow[i] = regs[i];
		end
		repeat (12) @(negedge clk_sys);
		resetn = 1'b1;
		repeat (6) @(negedge clk_sys);
		wr(own_address, 1'b1, 1);
		rd(own_address, 1'b1, 1'b1, 1, shadow[p]);
		wr(own_address, 1'b1, 2);
		rd(own_address, 1'b1, 1'b1, 2, shadow[p]);
		wr(7'h3a, 1'b0, 1);
		rd(own_address, 1'b1, 1'b0, 1, shadow[p]);
		wr(smb_pkg::BCAST_ADDR, 1'b0, 1);
		@(negedge clk_sys) broadcast_write_enable = 1'b1;
		wr(smb_pkg::BCAST_ADDR, 1'b1, 1);
		rd(smb_pkg::ARA_ADDR, 1'b0, 1'b0, 1, 8'hff);
		@(negedge clk_sys) alert_active = 1'b1;
		n_rel = 0;
		rd(smb_pkg::ARA_ADDR, 1'b1, 1'b0, 1, {own_address, 1'b0});
		check("release", n_rel > 0, 1'b1);
		check("left", exp_q.size() == 0, 1'b1);
		results();
	end
endmodule
bind smb_slave_port smb_props chk (.clk_sys(clk_sys), .resetn(resetn),
	.serial_clock(serial_clock), .serial_data_out(serial_data_out),
	.serial_data_oe(serial_data_oe), .reg_ptr(reg_ptr),
	.reg_wdata(reg_wdata), .reg_write(reg_write),
	.alert_release(alert_release));

//--- hdl/smb_pkg.sv
// shared constants and types for the two-wire slave port
// assumes nothing beyond a sv-2012 compiler
package smb_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int PTR_W = 3;
	// special bus addresses, seven bits without the direction bit
	localparam logic [6:0] BCAST_ADDR = 7'h5f;
	localparam logic [6:0] ARA_ADDR = 7'h0c;
	// bit counter positions within one nine-clock byte slot
	localparam logic [3:0] BIT_FIRST = 4'h1;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_RESET = 4'h0;
	// reset values
	localparam logic [2:0] PTR_RESET = 3'h0;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [6:0] OWN_RESET = 7'h00;
	// link states, gray along idle-addr-cmd-wdata-rdata
	typedef enum logic [2:0] {
		SMB_IDLE = 3'b000,
		SMB_ADDR = 3'b001,
		SMB_CMD = 3'b011,
		SMB_WDATA = 3'b010,
		SMB_RDATA = 3'b110,
		SMB_SKIP = 3'b100
	} smb_state_t;
endpackage

//--- hdl/smb_slave_port.sv
// two-wire slave port: byte/word reads and writes to a small register set
// assumes serial_clock is the bus clock, stopped between transfers, and the
// register set lives in the clk_sys domain behind reg_ptr / reg_rdata
//
// Behaviour
// - slave for Read Byte, Write Byte, Read Word and Write Word forms.
// - second byte of a word read repeats the first byte sent.
// - second byte of a word write is acknowledged then dropped.
// - data sampled on input pin, driven on separate open-drain output.
// - both lines rest high when idle; nobody pulls them low.
// - on the last command bit, low three command bits become the register pointer.
// - pointer survives the end of a transaction for repeated reads.
// - accept broadcast write address only when broadcast enable is set.
// - while alert is active, ack alert response address, return own address.
`timescale 1ns/10ps
module smb_slave_port (
	// system side clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// serial link, clock from the master
	input wire logic serial_clock,
	input wire logic serial_data_in,
	output logic serial_data_out,
	output logic serial_data_oe,
	// configuration and alert state from the device
	input wire logic [6:0] own_address,
	input wire logic broadcast_write_enable,
	input wire logic alert_active,
	// register set access
	input wire logic [7:0] reg_rdata,
	output logic [2:0] reg_ptr,
	output logic [7:0] reg_wdata,
	output logic reg_write,
	output logic alert_release
);
	logic start_pend;
	logic start_clr;
	logic stop_seen;
	smb_pkg::smb_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic [7:0] tx;
	logic ack_pend;
	logic tx_mode;
	logic ara_mode;
	logic first_byte;
	logic freeze;
	logic [2:0] ptr;
	logic [7:0] wbyte;
	logic wr_tgl;
	logic ptr_tgl;
	logic rel_tgl;
	logic [1:0] link_lvl;
	logic [3:0] sys_lvl;
	logic [2:0] tgl_hist;
	logic [7:0] rd_hold;
	logic [6:0] own_addr;
	logic [7:0] byte_in;
	logic tx_bit;

	// full address match, seven bits plus direction
	function automatic logic addr_is(input logic [7:0] b,
		input logic [6:0] a, input logic rw);
		return (b[7:1] == a) && (b[0] == rw);
	endfunction

	assign byte_in = {shift[6:0], serial_data_in};
	assign tx_bit = tx[3'(smb_pkg::BIT_LAST - bit_cnt)];

	// start: data falls with clock high; cleared by the first clock rise
	always_ff @(negedge serial_data_in or posedge start_clr or
		negedge resetn) begin
		if (!resetn)
			start_pend <= 1'b0;
		else if (start_clr)
			start_pend <= 1'b0;
		else if (serial_clock)
			start_pend <= 1'b1;
	end

	// stop: data rises with clock high; bus counts as free until a start
	always_ff @(posedge serial_data_in or posedge start_pend or
		negedge resetn) begin
		if (!resetn)
			stop_seen <= 1'b1;
		else if (start_pend)
			stop_seen <= 1'b0;
		else if (serial_clock)
			stop_seen <= 1'b1;
	end

	// start is consumed on the rise that also samples address bit 7
	always_ff @(posedge serial_clock or negedge resetn) begin
		if (!resetn)
			start_clr <= 1'b0;
		else
			start_clr <= start_pend;
	end

	// enable and alert levels into the link domain
	smb_sync #(.WIDTH(2)) u_link_sync (
		.clk(serial_clock),
		.din({broadcast_write_enable, alert_active}),
		.dout(link_lvl)
	);

	// protocol engine, samples on the clock rise
	always_ff @(posedge serial_clock or negedge resetn) begin
		if (!resetn) begin
			state <= smb_pkg::SMB_IDLE;
			bit_cnt <= smb_pkg::BIT_RESET;
			shift <= smb_pkg::DATA_RESET;
			tx <= smb_pkg::DATA_RESET;
			ack_pend <= 1'b0;
			tx_mode <= 1'b0;
			ara_mode <= 1'b0;
			first_byte <= 1'b0;
			freeze <= 1'b0;
			ptr <= smb_pkg::PTR_RESET;
			wbyte <= smb_pkg::DATA_RESET;
			wr_tgl <= 1'b0;
			ptr_tgl <= 1'b0;
			rel_tgl <= 1'b0;
		end else if (start_pend) begin
			// a repeated start restarts here; ptr is kept
			state <= smb_pkg::SMB_ADDR;
			bit_cnt <= smb_pkg::BIT_FIRST;
			shift <= {7'h00, serial_data_in};
			ack_pend <= 1'b0;
			tx_mode <= 1'b0;
			ara_mode <= 1'b0;
			freeze <= 1'b1;
		end else if (bit_cnt == smb_pkg::BIT_ACK) begin
			bit_cnt <= smb_pkg::BIT_RESET;
			ack_pend <= 1'b0;
			if (tx_mode && serial_data_in) begin
				// master nack ends the read
				state <= smb_pkg::SMB_SKIP;
				tx_mode <= 1'b0;
			end else begin
				// tx is left intact so a word read repeats it
				tx_mode <= (state == smb_pkg::SMB_RDATA);
			end
		end else begin
			bit_cnt <= bit_cnt + 4'h1;
			shift <= byte_in;
			if (tx_mode && ara_mode && tx_bit && !serial_data_in) begin
				// lost address arbitration to a lower address
				state <= smb_pkg::SMB_SKIP;
				tx_mode <= 1'b0;
			end else if (bit_cnt == smb_pkg::BIT_LAST) begin
				case (state)
				smb_pkg::SMB_ADDR: begin
					freeze <= 1'b0;
					if (byte_in[7:1] == own_addr) begin
						ack_pend <= 1'b1;
						rel_tgl <= ~rel_tgl;
						if (byte_in[0]) begin
							state <= smb_pkg::SMB_RDATA;
							tx <= rd_hold;
						end else begin
							state <= smb_pkg::SMB_CMD;
						end
					end else if (addr_is(byte_in, smb_pkg::BCAST_ADDR,
						1'b0) && link_lvl[1]) begin
						ack_pend <= 1'b1;
						state <= smb_pkg::SMB_CMD;
					end else if (addr_is(byte_in, smb_pkg::ARA_ADDR,
						1'b1) && link_lvl[0]) begin
						ack_pend <= 1'b1;
						state <= smb_pkg::SMB_RDATA;
						ara_mode <= 1'b1;
						tx <= {own_addr, 1'b0};
					end else begin
						state <= smb_pkg::SMB_SKIP;
					end
				end
				smb_pkg::SMB_CMD: begin
					ack_pend <= 1'b1;
					ptr <= byte_in[2:0];
					ptr_tgl <= ~ptr_tgl;
					state <= smb_pkg::SMB_WDATA;
					first_byte <= 1'b1;
				end
				smb_pkg::SMB_WDATA: begin
					ack_pend <= 1'b1; // later bytes acked
					if (first_byte) begin
						wbyte <= byte_in;
						wr_tgl <= ~wr_tgl;
						first_byte <= 1'b0;
					end
				end
				smb_pkg::SMB_RDATA: begin
					if (ara_mode) begin
						// won arbitration: release our alert once
						rel_tgl <= ~rel_tgl;
						ara_mode <= 1'b0;
					end
				end
				default: ;
				endcase
			end
		end
	end

	// drive on the clock fall so data is stable across the high phase
	always_ff @(negedge serial_clock or negedge resetn) begin
		if (!resetn) begin
			serial_data_out <= 1'b0;
			serial_data_oe <= 1'b0;
		end else begin
			serial_data_out <= 1'b0; // open drain only ever pulls low
			if (stop_seen || start_pend)
				serial_data_oe <= 1'b0;
			else if (bit_cnt == smb_pkg::BIT_ACK)
				serial_data_oe <= ack_pend;
			else
				serial_data_oe <= tx_mode && !tx_bit;
		end
	end

	// toggles and the freeze level into the system domain
	smb_sync #(.WIDTH(4)) u_sys_sync (
		.clk(clk_sys),
		.din({wr_tgl, ptr_tgl, rel_tgl, freeze}),
		.dout(sys_lvl)
	);

	// system side: event pulses, pointer and data copies
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			tgl_hist <= 3'h0;
			reg_write <= 1'b0;
			alert_release <= 1'b0;
			reg_ptr <= smb_pkg::PTR_RESET;
			reg_wdata <= smb_pkg::DATA_RESET;
		end else begin
			tgl_hist <= sys_lvl[3:1];
			reg_write <= sys_lvl[3] ^ tgl_hist[2];
			alert_release <= sys_lvl[1] ^ tgl_hist[0];
			// link copies are stable two edges before the toggle lands
			if (sys_lvl[3] ^ tgl_hist[2])
				reg_wdata <= wbyte;
			if (sys_lvl[2] ^ tgl_hist[1])
				reg_ptr <= ptr;
		end
	end

	// read data held still while the link may load it
	always_ff @(posedge clk_sys) begin
		if (!resetn)
			rd_hold <= smb_pkg::DATA_RESET;
		else if (!sys_lvl[0])
			rd_hold <= reg_rdata;
	end

	// own address is a strap: caught after release, static afterwards
	always_ff @(posedge clk_sys) begin
		if (!resetn)
			own_addr <= smb_pkg::OWN_RESET;
		else
			own_addr <= own_address;
	end
endmodule

//--- hdl/smb_sync.sv
// two-flop synchroniser for levels and toggles
// assumes each bit is a level or toggle that holds for two edges of clk
`timescale 1ns/10ps
module smb_sync #(
	parameter int WIDTH = 1
) (
	// clock of the receiving domain
	input wire logic clk,
	// levels from the other domain
	input wire logic [WIDTH-1:0] din,
	// synchronised levels
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta;

	// first stage feeds only the second stage
	always_ff @(posedge clk) begin
		meta <= din;
		dout <= meta;
	end
endmodule
